// File: verilog/acc_pkg.sv
// package: register map, field positions, reset values and timebase codes
package acc_pkg;
    localparam logic [7:0] CTRL_ADDR     = 8'hD8;
    localparam logic [7:0] MODE_ADDR     = 8'hD9;
    // control register fields
    localparam int         CTL_OVF_BIT   = 7;
    localparam int         CTL_RUN_BIT   = 6;
    localparam int         CTL_EVT2_BIT  = 2;
    localparam logic [7:0] CTL_RESET     = 8'h00;
    localparam logic [7:0] CTL_USED_MASK = 8'hC7;
    // mode register fields
    localparam int         MD_IDLE_BIT   = 7;
    localparam int         MD_WDE_BIT    = 6;
    localparam int         MD_LOCK_BIT   = 5;
    localparam int         MD_TB_LSB     = 1;
    localparam int         MD_OVIE_BIT   = 0;
    localparam logic [7:0] MD_RESET      = 8'h40;
    localparam logic [7:0] MD_USED_MASK  = 8'hEF;
    // timebase select codes
    typedef enum logic [2:0] {
        TB_DIV12 = 3'h0,
        TB_DIV4  = 3'h1,
        TB_T0OV  = 3'h2,
        TB_EXTIN = 3'h3,
        TB_SYS   = 3'h4,
        TB_XDIV8 = 3'h5,
        TB_LDIV8 = 3'h6,
        TB_NONE  = 3'h7
    } acc_tb_t;
    localparam logic [3:0] DIV12_LAST    = 4'hB;
    localparam logic [1:0] DIV4_LAST     = 2'h3;
    localparam logic [2:0] DIV8_LAST     = 3'h7;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
endpackage

// File: verilog/acc_tick_if.sv
// interface: timebase tick from the prescaler to the counter core
`timescale 1ns/100ps
interface acc_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// File: verilog/acc_tb_sel.sv
// timebase generator: prescalers, edge detect, divided-clock synchroniser
`timescale 1ns/100ps
module acc_tb_sel
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // sources and selection
    input  wire logic [2:0] sel,
    input  wire logic       timer0_ovf,
    input  wire logic       ext_count_in,
    input  wire logic       ext_osc_clk,
    input  wire logic       lf_osc_clk,
    acc_tick_if.src         tk
);
    logic [3:0] div12_q;
    logic [1:0] div4_q;
    logic       eci_s1_q, eci_s2_q, eci_prev_q;
    logic [2:0] xdiv_q, ldiv_q;
    logic       x_s1_q, x_s2_q, x_prev_q;
    logic       l_s1_q, l_s2_q, l_prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div12_q <= '0;
            div4_q  <= '0;
        end else begin
            div12_q <= (div12_q == DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
            div4_q  <= div4_q + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eci_s1_q <= 1'b1;
            eci_s2_q <= 1'b1;
            eci_prev_q <= 1'b1;
        end else begin
            eci_s1_q <= ext_count_in;
            eci_s2_q <= eci_s1_q;
            eci_prev_q <= eci_s2_q;
        end
    end

    // divide-by-8 on the foreign oscillators; msb then crosses into clk
    always_ff @(posedge ext_osc_clk or posedge rst) begin
        if (rst) xdiv_q <= '0;
        else     xdiv_q <= xdiv_q + 3'h1;
    end
    always_ff @(posedge lf_osc_clk or posedge rst) begin
        if (rst) ldiv_q <= '0;
        else     ldiv_q <= ldiv_q + 3'h1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            x_s1_q <= 1'b0; x_s2_q <= 1'b0; x_prev_q <= 1'b0;
            l_s1_q <= 1'b0; l_s2_q <= 1'b0; l_prev_q <= 1'b0;
        end else begin
            x_s1_q <= xdiv_q[2]; x_s2_q <= x_s1_q; x_prev_q <= x_s2_q;
            l_s1_q <= ldiv_q[2]; l_s2_q <= l_s1_q; l_prev_q <= l_s2_q;
        end
    end

    always_comb begin
        unique case (acc_tb_t'(sel))
            TB_DIV12: tk.tick = (div12_q == DIV12_LAST);
            TB_DIV4:  tk.tick = (div4_q == DIV4_LAST);
            TB_T0OV:  tk.tick = timer0_ovf;
            TB_EXTIN: tk.tick = eci_prev_q & ~eci_s2_q;
            TB_SYS:   tk.tick = 1'b1;
            TB_XDIV8: tk.tick = x_s2_q & ~x_prev_q;
            TB_LDIV8: tk.tick = l_s2_q & ~l_prev_q;
            TB_NONE:  tk.tick = 1'b0;
        endcase
    end
endmodule

// File: verilog/acc_core.sv
// counter array control and mode registers with the 16-bit array counter
`timescale 1ns/100ps
// Behaviour
// - overflow flag sets when counter wraps from all ones to zero
// - overflow flag raises interrupt request only when overflow enable is one
// - hardware never clears flags; software writes zero to clear them
// - run bit zero stops counter, one lets it count
// - control bits 5..3 read zero, writes ignored
// - one event flag per module at bits 2..0, set on match or capture
// - enabled module flag being set raises the shared interrupt request
// - idle suspend bit halts the array while the processor idles
// - watchdog enable bit 6, reset one, puts module 2 in watchdog use
// - lock bit keeps watchdog enabled until next system reset
// - three-bit select picks the counter timebase source
// - code 011 counts falling edges on external input, max quarter clock
// - code 101 divides external oscillator by eight, synchronised
// - while watchdog enabled, other mode bits cannot be modified
// - mode bit 4 reads zero, writes ignored
// - control register supports single bit set and clear
// - watchdog enabled forces counter on, freezes select and idle bits
// - with watchdog on run writes do not stop counter; run reads stored bit
// - watchdog on and write one to module 2 flag causes reset
// - reset leaves watchdog enabled, timebase divide-by-twelve
module acc_core
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        bit_wr,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        bit_val,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // timebase sources
    input  wire logic        timer0_ovf,
    input  wire logic        ext_count_in,
    input  wire logic        ext_osc_clk,
    input  wire logic        lf_osc_clk,
    // system
    input  wire logic        cpu_idle,
    input  wire logic [2:0]  module_event,
    input  wire logic [2:0]  module_irq_enable,
    // outputs
    output logic             counter_array_irq,
    output logic [15:0]      array_count,
    output logic             counter_overflow,
    output logic             count_tick,
    output logic             watchdog_active,
    output logic             watchdog_sw_reset
);
    logic [7:0]  ctl_q;
    logic [7:0]  md_q;
    logic [15:0] cnt_q;
    logic [7:0]  rdata_q;
    logic        swrst_q;
    logic        ctl_wr, md_wr;
    logic [7:0]  ctl_wval;
    logic        wde, run_eff, active, step, wrap;
    acc_tick_if  tk_if ();

    acc_tb_sel u_tb (
        .clk          (clk),
        .rst          (rst),
        .sel          (md_q[MD_TB_LSB +: 3]),
        .timer0_ovf   (timer0_ovf),
        .ext_count_in (ext_count_in),
        .ext_osc_clk  (ext_osc_clk),
        .lf_osc_clk   (lf_osc_clk),
        .tk           (tk_if.src)
    );

    // whole-byte write or a single-bit read-modify-write on the control byte
    always_comb begin
        ctl_wval = ctl_q;
        ctl_wr   = 1'b0;
        if (reg_wr && reg_addr == CTRL_ADDR) begin
            ctl_wval = reg_wdata;
            ctl_wr   = 1'b1;
        end else if (bit_wr) begin
            ctl_wval[bit_sel] = bit_val;
            ctl_wr   = 1'b1;
        end
    end
    assign md_wr = reg_wr && reg_addr == MODE_ADDR;

    assign wde     = md_q[MD_WDE_BIT];
    assign run_eff = ctl_q[CTL_RUN_BIT] | wde;
    assign active  = run_eff & ~(md_q[MD_IDLE_BIT] & cpu_idle);
    assign step    = active & tk_if.tick;
    assign wrap    = step & (cnt_q == CNT_MAX);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_q <= '0;
        else if (step) cnt_q <= cnt_q + 16'h0001;
    end

    // flags: hardware set beats a software clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_q <= CTL_RESET;
        end else begin
            if (ctl_wr)
                ctl_q <= ctl_wval & CTL_USED_MASK;
            if (wrap | (ctl_wr ? ctl_wval[CTL_OVF_BIT] : ctl_q[CTL_OVF_BIT]))
                ctl_q[CTL_OVF_BIT] <= 1'b1;
            else
                ctl_q[CTL_OVF_BIT] <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                ctl_q[i] <= module_event[i] | (ctl_wr ? ctl_wval[i] : ctl_q[i]);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            md_q <= MD_RESET;
        end else if (md_wr) begin
            if (!wde) begin
                md_q <= reg_wdata & MD_USED_MASK;
            end else begin
                // only enable and lock may move while the watchdog runs
                md_q[MD_LOCK_BIT] <= md_q[MD_LOCK_BIT] | reg_wdata[MD_LOCK_BIT];
                md_q[MD_WDE_BIT]  <= reg_wdata[MD_WDE_BIT] | md_q[MD_LOCK_BIT]
                                     | reg_wdata[MD_LOCK_BIT];
            end
            if (!wde && reg_wdata[MD_LOCK_BIT])
                md_q[MD_WDE_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) swrst_q <= 1'b0;
        else     swrst_q <= wde & ctl_wr & ctl_wval[CTL_EVT2_BIT];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                CTRL_ADDR: rdata_q <= ctl_q & CTL_USED_MASK;
                MODE_ADDR: rdata_q <= md_q & MD_USED_MASK;
                default:   rdata_q <= '0;
            endcase
        end
    end

    assign reg_rdata         = rdata_q;
    assign counter_array_irq = (ctl_q[CTL_OVF_BIT] & md_q[MD_OVIE_BIT])
                               | |(ctl_q[2:0] & module_irq_enable);
    assign array_count       = cnt_q;
    assign counter_overflow  = wrap;
    assign count_tick        = step;
    assign watchdog_active   = wde;
    assign watchdog_sw_reset = swrst_q;
endmodule

// File: sim/acc_chk_props.sv
// checker: port properties of the counter array core
`timescale 1ns/100ps
module acc_chk
    import acc_pkg::*;
(
    // clock, reset, register port
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // counter and watchdog
    input wire logic [15:0] array_count,
    input wire logic        counter_overflow,
    input wire logic        count_tick,
    input wire logic        watchdog_active,
    input wire logic        watchdog_sw_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic lock_q;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            lock_q <= 1'b0;
        else if (reg_wr && reg_addr == MODE_ADDR && reg_wdata[5])
            lock_q <= 1'b1;
    sequence s_ctl_rd;
        reg_rd && reg_addr == CTRL_ADDR;
    endsequence
    sequence s_md_rd;
        reg_rd && reg_addr == MODE_ADDR;
    endsequence
    a_wrap_at_max:
    assert property (counter_overflow |-> count_tick && array_count == CNT_MAX)
        else $error("bad wrap");
    a_count_step:
    assert property (count_tick |=> array_count == $past(array_count) + 16'h0001)
        else $error("bad step");
    a_count_hold:
    assert property (!count_tick |=> $stable(array_count))
        else $error("count moved");
    a_ctl_unused:
    assert property (s_ctl_rd |=> reg_rdata[5:3] == 3'h0)
        else $error("control bits 5:3 set");
    a_mode_unused:
    assert property (s_md_rd |=> reg_rdata[4] == 1'b0)
        else $error("mode bit 4 set");
    a_mode_enable:
    assert property (s_md_rd |=> reg_rdata[6] == $past(watchdog_active))
        else $error("enable bit mismatch");
    a_lock_holds:
    assert property (lock_q |-> watchdog_active)
        else $error("locked watchdog off");
    a_sw_reset_on:
    assert property (reg_wr && reg_addr == CTRL_ADDR && reg_wdata[2] && watchdog_active
        |=> watchdog_sw_reset)
        else $error("no forced reset");
endmodule
bind acc_core acc_chk u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .array_count, .counter_overflow, .count_tick, .watchdog_active,
    .watchdog_sw_reset);

// File: sim/acc_src_model.sv
// partner: timer 0, external count and oscillator sources
`timescale 1ns/100ps
module acc_src_model (
    // system clock in, sources out
    input  wire logic clk,
    output logic      timer0_ovf,
    output logic      ext_count_in,
    output logic      ext_osc_clk,
    output logic      lf_osc_clk
);
    logic [3:0] n_q = 4'h0;
    logic       xo_q = 1'b0;
    logic       lo_q = 1'b0;
    always #35 xo_q = ~xo_q;
    always #165 lo_q = ~lo_q;
    always_ff @(posedge clk)
        n_q <= n_q + 4'h1;
    assign timer0_ovf   = n_q == 4'hF;
    // one fall per 8 clocks, under a quarter of the clock rate
    assign ext_count_in = n_q[2];
    assign ext_osc_clk  = xo_q;
    assign lf_osc_clk   = lo_q;
endmodule

// File: sim/array_counter_control_mode_tb_top.sv
// testbench: register tests of the counter array core
`timescale 1ns/100ps
module array_counter_control_mode_tb_top;
    import acc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, bit_wr = 1'b0;
    logic        bit_val = 1'b0, cpu_idle = 1'b0, timer0_ovf, ext_count_in, ext_osc_clk;
    logic        lf_osc_clk, counter_array_irq, watchdog_active, watchdog_sw_reset;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0]  bit_sel = 3'h0, module_event = 3'h0, module_irq_enable = 3'h0;
    logic [15:0] array_count, d;
    logic [15:0] exp_t [8] = '{16'h0008, 16'h0018, 16'h0006, 16'h000C, 16'h0060,
                               16'h0000, 16'h0000, 16'h0000};
    int          miscompares = 0, checked = 0, cycles = 0;
    acc_src_model src (.clk, .timer0_ovf, .ext_count_in, .ext_osc_clk, .lf_osc_clk);
    acc_core dut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .bit_wr, .bit_sel, .bit_val,
        .reg_rd, .reg_rdata, .timer0_ovf, .ext_count_in, .ext_osc_clk, .lf_osc_clk,
        .cpu_idle, .module_event, .module_irq_enable, .counter_array_irq, .array_count,
        .counter_overflow(), .count_tick(), .watchdog_active, .watchdog_sw_reset);
    always #50 clk = ~clk;
    task automatic close_out;
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic cmp(input logic [15:0] g, e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask
    task automatic bwr(input logic [2:0] s, input logic v);
        @(posedge clk);
        bit_sel <= s;
        bit_val <= v;
        bit_wr  <= 1'b1;
        @(posedge clk);
        bit_wr  <= 1'b0;
        #1;
    endtask
    task automatic chk(input logic [7:0] a, e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 cmp(16'(reg_rdata), 16'(e));
    endtask
    // count gained over 96 clocks
    task automatic win(output logic [15:0] n);
        logic [15:0] c0;
        repeat (4) @(posedge clk);
        #1 c0 = array_count;
        repeat (96) @(posedge clk);
        #1 n = array_count - c0;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(CTRL_ADDR, 8'h00);
        chk(MODE_ADDR, 8'h40);
        wr(CTRL_ADDR, 8'h38);
        chk(CTRL_ADDR, 8'h00);
        wr(MODE_ADDR, 8'hCF);
        chk(MODE_ADDR, 8'h40);
        wr(CTRL_ADDR, 8'h04);
        cmp(16'(watchdog_sw_reset), 16'h0001);
        chk(CTRL_ADDR, 8'h04);
        wr(CTRL_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h00);
        cmp(16'(watchdog_active), 16'h0000);
        wr(MODE_ADDR, 8'h1F);
        chk(MODE_ADDR, 8'h0F);
        bwr(3'h6, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(MODE_ADDR, {4'h0, 3'(i), 1'b0});
            win(d);
            if (i == 5 || i == 6)
                cmp(16'(d != 16'h0000), 16'h0001);
            else
                cmp(d, exp_t[i]);
        end
        wr(MODE_ADDR, 8'h08);
        bwr(3'h6, 1'b0);
        win(d);
        cmp(d, 16'h0000);
        bwr(3'h6, 1'b1);
        @(posedge clk) cpu_idle <= 1'b1;
        wr(MODE_ADDR, 8'h88);
        win(d);
        cmp(d, 16'h0000);
        wr(MODE_ADDR, 8'h09);
        win(d);
        cmp(d, 16'h0060);
        @(posedge clk) cpu_idle <= 1'b0;
        while (array_count !== 16'hFFFF)
            @(negedge clk);
        @(negedge clk);
        cmp(16'(counter_array_irq), 16'h0001);
        chk(CTRL_ADDR, 8'hC0);
        wr(MODE_ADDR, 8'h08);
        cmp(16'(counter_array_irq), 16'h0000);
        wr(CTRL_ADDR, 8'h40);
        chk(CTRL_ADDR, 8'h40);
        @(posedge clk);
        module_event      <= 3'h7;
        module_irq_enable <= 3'h2;
        @(posedge clk);
        module_event      <= 3'h0;
        #1 cmp(16'(counter_array_irq), 16'h0001);
        @(posedge clk) module_irq_enable <= 3'h0;
        @(negedge clk);
        cmp(16'(counter_array_irq), 16'h0000);
        chk(CTRL_ADDR, 8'h47);
        wr(MODE_ADDR, 8'h20);
        wr(MODE_ADDR, 8'h00);
        cmp(16'(watchdog_active), 16'h0001);
        bwr(3'h2, 1'b1);
        cmp(16'(watchdog_sw_reset), 16'h0001);
        close_out();
    end
endmodule
